/* File: design/irq_sleep_ctrl.sv */
// Purpose: Interrupt entry, priority, option register and WAIT/STOP control
// Assumes: Core pulses instruction boundary, WAIT, STOP and return events
// Notes:   Pins are synchronised; CPU cycle is a 13-clock enable
//
// What this block does
// - Entry swaps active flags to service pair, or NMI pair for NMI.
// - Entry pushes current program counter onto top of stack.
// - Normal requests blocked during service; NMI still accepted.
// - Entry loads its vector, then clears accepted source latch next cycle.
// - Vectors: A FF6, B FF4, NMI FFC, reset FFE, timer FF2, ADC FF0.
// - Return from service restores normal flags and re-enables requests.
// - Request in first 3 cycles of clearing write keeps normal flags.
// - Vector load to routine ready always takes 6 CPU cycle ticks.
// - One CPU cycle lasts 13 oscillator cycles.
// - Option register at C8 resets to zero and is write-only.
// - Option bit 6: port A falling edge or low level.
// - Option bit 5: port B falling or rising edge.
// - Option bit 4 globally enables maskable interrupts.
// - With enable clear, NMI is served but does not wake.
// - After reset, device starts in RUN mode.
// - WAIT halts execution, oscillator keeps running.
// - WAIT exits on reset, peripheral or pin interrupt.
// - STOP halts execution and stops the oscillator.
// - STOP exits on pin or timer interrupt, not converter.
// - Every STOP exit waits 2048 clocks before vectoring.
// - With watchdog, STOP acts as WAIT unless option set and NMI high.
// - Priority NMI, port A, port B, timer, converter.
// - Events during disabled enable stay latched for later.
// - NMI falling edge sets latch cleared on NMI entry.
// - WAIT and STOP not executed while enabled request pending.
module irq_sleep_ctrl (
    // APB
    input  wire logic                 pclk,
    input  wire logic                 presetn,
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // Pins
    input  wire logic                 nmi_pin,
    input  wire logic                 port_a_pin,
    input  wire logic                 port_b_pin,
    // Peripheral flags, same clock
    input  wire logic                 timer_underflow_flag,
    input  wire logic                 converter_done_flag,
    // Core
    input  wire logic                 instr_boundary,
    input  wire logic [11:0]          core_pc,
    input  wire logic                 wait_exec,
    input  wire logic                 stop_exec,
    input  wire logic                 return_from_service,
    input  wire logic                 option_clear_early,
    input  wire logic                 watchdog_active,
    input  wire logic                 stop_with_watchdog_option,
    output irq_sleep_pkg::entry_t     entry,
    output logic                      routine_ready,
    output logic                      cpu_halted,
    output logic                      osc_enable,
    output logic                      watchdog_freeze,
    output logic                      cpu_tick
);
    localparam logic [3:0] TICK_LAST = 4'(irq_sleep_pkg::OSC_PER_CPU - 1);
    localparam logic [3:0] RESP_LAST = 4'(irq_sleep_pkg::RESP_MIN_CPU - 1);
    localparam logic [10:0] WAKE_LAST =
        11'(irq_sleep_pkg::STOP_WAKE_CYC - 1);

    // Synchronisers
    logic [2:0] sync1;
    logic [2:0] sync2;
    logic [2:0] prev;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1 <= 3'h7;
            sync2 <= 3'h7;
            prev  <= 3'h7;
        end else begin
            sync1 <= {port_b_pin, port_a_pin, nmi_pin};
            sync2 <= sync1;
            prev  <= sync2;
        end
    end
    wire nmi_s = sync2[0];
    wire pa_s  = sync2[1];
    wire pb_s  = sync2[2];

    // CPU cycle divider
    logic [3:0] div_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            div_cnt <= 4'h0;
        else if (osc_enable)
            div_cnt <= (div_cnt == TICK_LAST) ? 4'h0 : div_cnt + 4'h1;
    end
    assign cpu_tick = osc_enable && (div_cnt == TICK_LAST);

    // Option register, write-only
    logic [7:0] option_reg;
    wire apb_access = psel && penable;
    wire opt_write  = apb_access && pwrite &&
                      (paddr == irq_sleep_pkg::OPTION_ADDR);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            option_reg <= irq_sleep_pkg::OPTION_RESET;
        else if (opt_write)
            option_reg <= pwdata[7:0] & irq_sleep_pkg::OPTION_MASK;
    end
    wire level_sel  = option_reg[irq_sleep_pkg::LEVEL_SEL_BIT];
    wire edge_rise  = option_reg[irq_sleep_pkg::EDGE_SEL_BIT];
    wire global_en  = option_reg[irq_sleep_pkg::GLOBAL_EN_BIT];

    // Edge detection
    wire nmi_fall = prev[0] && !nmi_s;
    wire pa_fall  = prev[1] && !pa_s;
    wire pb_edge  = edge_rise ? (!prev[2] && pb_s)
                              : (prev[2] && !pb_s);

    // Request latches
    logic nmi_latch;
    logic pa_latch;
    logic pb_latch;
    logic [2:0] take_sel;
    logic       take;
    wire clr_nmi = take && take_sel == 3'd0;
    wire clr_pa  = take && take_sel == 3'd1;
    wire clr_pb  = take && take_sel == 3'd2;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nmi_latch <= 1'b0;
            pa_latch  <= 1'b0;
            pb_latch  <= 1'b0;
        end else begin
            // Set wins over clear
            nmi_latch <= nmi_fall || (nmi_latch && !clr_nmi);
            pa_latch  <= pa_fall || (pa_latch && !clr_pa);
            pb_latch  <= pb_edge || (pb_latch && !clr_pb);
        end
    end

    // Pending requests
    wire pa_req  = level_sel ? !pa_s : pa_latch;
    wire [3:0] mask_req = {converter_done_flag, timer_underflow_flag,
                           pb_latch, pa_req};
    logic [1:0] flag_mode;
    wire in_service = flag_mode != 2'(irq_sleep_pkg::FLAGS_NORMAL);
    logic       in_nmi;
    logic       nmi_from_svc;
    wire mask_ok = global_en && !in_service;
    wire [3:0] mask_pend = mask_req & {4{mask_ok}};
    wire nmi_pend = nmi_latch && !in_nmi;
    wire any_pend = nmi_pend || (|mask_pend);

    function automatic logic [2:0] pick(input logic nmi,
                                        input logic [3:0] m);
        if (nmi)       pick = 3'd0;
        else if (m[0]) pick = 3'd1;
        else if (m[1]) pick = 3'd2;
        else if (m[2]) pick = 3'd3;
        else           pick = 3'd4;
    endfunction

    function automatic logic [11:0] vec_of(input logic [2:0] s);
        case (s)
            3'd0:    vec_of = irq_sleep_pkg::VEC_NMI;
            3'd1:    vec_of = irq_sleep_pkg::VEC_PORT_A;
            3'd2:    vec_of = irq_sleep_pkg::VEC_PORT_B;
            3'd3:    vec_of = irq_sleep_pkg::VEC_TIMER;
            default: vec_of = irq_sleep_pkg::VEC_CONVERTER;
        endcase
    endfunction

    wire [2:0] winner = pick(nmi_pend, mask_pend);

    // Wake sources
    wire wake_wait = global_en && (|mask_req || nmi_latch);
    wire wake_stop = global_en &&
                     (nmi_latch || mask_req[0] || pb_latch ||
                      timer_underflow_flag);
    wire stop_real = !watchdog_active ||
                     (stop_with_watchdog_option && nmi_s);

    // Power and entry sequencing
    irq_sleep_pkg::power_state_t state;
    logic [10:0] wake_cnt;
    logic [3:0]  resp_cnt;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state         <= irq_sleep_pkg::ST_RUN;
            wake_cnt      <= 11'h0;
            resp_cnt      <= 4'h0;
            flag_mode     <= 2'(irq_sleep_pkg::FLAGS_NORMAL);
            in_nmi        <= 1'b0;
            nmi_from_svc  <= 1'b0;
            take          <= 1'b0;
            take_sel      <= 3'd0;
            entry         <= '0;
            routine_ready <= 1'b0;
        end else begin
            take          <= 1'b0;
            routine_ready <= 1'b0;
            entry.valid   <= 1'b0;
            unique case (state)
                irq_sleep_pkg::ST_RUN: begin
                    if (instr_boundary && any_pend) begin
                        take     <= 1'b1;
                        take_sel <= winner;
                        entry.valid  <= 1'b1;
                        entry.vector <= vec_of(winner);
                        entry.stacked_pc <= core_pc;
                        if (winner == 3'd0) begin
                            entry.flags <= irq_sleep_pkg::FLAGS_NMI;
                            in_nmi      <= 1'b1;
                            // Nested NMI hands service mode back
                            nmi_from_svc <= in_service &&
                                            !return_from_service;
                        end else if (option_clear_early)
                            entry.flags <= irq_sleep_pkg::FLAGS_NORMAL;
                        else
                            entry.flags <= irq_sleep_pkg::FLAGS_SERVICE;
                        flag_mode <= (winner == 3'd0)
                            ? 2'(irq_sleep_pkg::FLAGS_NMI)
                            : 2'(irq_sleep_pkg::FLAGS_SERVICE);
                        resp_cnt <= 4'h0;
                        state    <= irq_sleep_pkg::ST_ENTRY;
                    end else if (return_from_service) begin
                        if (in_nmi) begin
                            in_nmi    <= 1'b0;
                            flag_mode <= nmi_from_svc
                                ? 2'(irq_sleep_pkg::FLAGS_SERVICE)
                                : 2'(irq_sleep_pkg::FLAGS_NORMAL);
                        end else
                            flag_mode <= 2'(irq_sleep_pkg::FLAGS_NORMAL);
                    end else if (stop_exec && !any_pend) begin
                        state <= stop_real ? irq_sleep_pkg::ST_STOP
                                           : irq_sleep_pkg::ST_WAIT;
                    end else if (wait_exec && !any_pend)
                        state <= irq_sleep_pkg::ST_WAIT;
                end
                irq_sleep_pkg::ST_WAIT: begin
                    if (wake_wait)
                        state <= irq_sleep_pkg::ST_RUN;
                end
                irq_sleep_pkg::ST_STOP: begin
                    if (wake_stop) begin
                        wake_cnt <= 11'h0;
                        state    <= irq_sleep_pkg::ST_RESTART;
                    end
                end
                irq_sleep_pkg::ST_RESTART: begin
                    wake_cnt <= wake_cnt + 11'h1;
                    if (wake_cnt == WAKE_LAST)
                        state <= irq_sleep_pkg::ST_RUN;
                end
                irq_sleep_pkg::ST_ENTRY: begin
                    if (cpu_tick) begin
                        resp_cnt <= resp_cnt + 4'h1;
                        if (resp_cnt == RESP_LAST) begin
                            routine_ready <= 1'b1;
                            state <= irq_sleep_pkg::ST_RUN;
                        end
                    end
                end
                default: state <= irq_sleep_pkg::ST_RUN;
            endcase
        end
    end

    assign cpu_halted = state == irq_sleep_pkg::ST_WAIT ||
                        state == irq_sleep_pkg::ST_STOP ||
                        state == irq_sleep_pkg::ST_RESTART;
    assign osc_enable = state != irq_sleep_pkg::ST_STOP;
    assign watchdog_freeze = state == irq_sleep_pkg::ST_STOP ||
                             state == irq_sleep_pkg::ST_RESTART;

    // APB answer: status readable, option reads zero
    wire status_rd = apb_access && !pwrite &&
                     (paddr == irq_sleep_pkg::STATUS_ADDR);
    wire mapped = paddr == irq_sleep_pkg::OPTION_ADDR ||
                  paddr == irq_sleep_pkg::STATUS_ADDR;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0;
        else if (psel && !penable)
            prdata <= (!pwrite && paddr == irq_sleep_pkg::STATUS_ADDR)
                ? {24'h0, state, flag_mode, nmi_latch, pb_latch, pa_latch}
                : 32'h0;
    end
    assign pready  = 1'b1;
    assign pslverr = apb_access && !mapped;

    // Checks
    a_wake_delay_len: assert property (@(posedge pclk) disable iff (!presetn)
        state == irq_sleep_pkg::ST_STOP && wake_stop |=> cpu_halted [*8])
        else $error("stop restart ended too early");
    a_entry_vector_nmi: assert property (@(posedge pclk)
        disable iff (!presetn)
        entry.valid && entry.flags == irq_sleep_pkg::FLAGS_NMI
        |-> entry.vector == irq_sleep_pkg::VEC_NMI)
        else $error("nmi entry used wrong vector");
    a_option_write: assert property (@(posedge pclk) disable iff (!presetn)
        opt_write |=> global_en == $past(pwdata[4]))
        else $error("option write not applied");
    a_no_nest_mask: assert property (@(posedge pclk) disable iff (!presetn)
        in_service && !in_nmi && entry.valid |->
        entry.flags == irq_sleep_pkg::FLAGS_NMI || $past(!in_service))
        else $error("maskable entry nested");
    a_latch_clear: assert property (@(posedge pclk) disable iff (!presetn)
        take && take_sel == 3'd0 && !nmi_fall |=> !nmi_latch)
        else $error("nmi latch not cleared");
    a_no_sleep_pend: assert property (@(posedge pclk) disable iff (!presetn)
        state == irq_sleep_pkg::ST_RUN && any_pend && !instr_boundary
        |=> !cpu_halted)
        else $error("sleep entered with pending request");
    a_stop_no_adc: assert property (@(posedge pclk) disable iff (!presetn)
        state == irq_sleep_pkg::ST_STOP && !nmi_latch && !pa_req &&
        !pb_latch && !timer_underflow_flag |=> state == irq_sleep_pkg::ST_STOP)
        else $error("stop left without a wake source");
    a_entry_pc_stack: assert property (@(posedge pclk) disable iff (!presetn)
        state == irq_sleep_pkg::ST_RUN && instr_boundary && any_pend
        |=> entry.valid && entry.stacked_pc == $past(core_pc))
        else $error("pc not stacked on entry");
    a_ready_delay: assert property (@(posedge pclk) disable iff (!presetn)
        entry.valid |-> !routine_ready [*8])
        else $error("routine ready too soon");
endmodule

/* File: design/irq_sleep_pkg.sv */
// Purpose: Shared constants and types for interrupt entry and sleep control
// Assumes: pclk at 200 MHz, APB register access
// Notes:   Program addresses are 12 bits wide
package irq_sleep_pkg;
    // Register map, byte addresses
    localparam logic [11:0] OPTION_ADDR     = 12'h0c8;
    localparam logic [11:0] STATUS_ADDR     = 12'h0cc;
    localparam logic [7:0]  OPTION_RESET    = 8'h00;
    // Option fields
    localparam int          LEVEL_SEL_BIT   = 6;
    localparam int          EDGE_SEL_BIT    = 5;
    localparam int          GLOBAL_EN_BIT   = 4;
    localparam logic [7:0]  OPTION_MASK     = 8'h70;
    // Vector addresses
    localparam logic [11:0] VEC_RESET       = 12'hffe;
    localparam logic [11:0] VEC_NMI         = 12'hffc;
    localparam logic [11:0] VEC_PORT_A      = 12'hff6;
    localparam logic [11:0] VEC_PORT_B      = 12'hff4;
    localparam logic [11:0] VEC_TIMER       = 12'hff2;
    localparam logic [11:0] VEC_CONVERTER   = 12'hff0;
    // Timing
    localparam int          OSC_PER_CPU     = 13;
    localparam int          RESP_MIN_CPU    = 6;
    localparam int          RESP_MAX_CPU    = 11;
    localparam int          STOP_WAKE_CYC   = 2048;
    localparam int          EARLY_LDI_CYC   = 3;

    typedef enum logic [1:0] {
        FLAGS_NORMAL  = 2'b00,
        FLAGS_SERVICE = 2'b01,
        FLAGS_NMI     = 2'b10
    } flag_set_t;

    typedef enum logic [2:0] {
        ST_RUN     = 3'b000,
        ST_WAIT    = 3'b001,
        ST_STOP    = 3'b010,
        ST_RESTART = 3'b011,
        ST_ENTRY   = 3'b100
    } power_state_t;

    // Entry command to the core
    typedef struct packed {
        logic        valid;
        logic [11:0] vector;
        logic [11:0] stacked_pc;
        flag_set_t   flags;
    } entry_t;
endpackage

/* File: verification/core_model.sv */
// Purpose: Core model on the far side of the interrupt entry logic
// Assumes: Fixed 8-clock instructions while the core is not halted
// Notes:   Each service routine is a short fixed delay, then a return
module core_model (
    // Clock and reset
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    // From the entry logic
    input  wire irq_sleep_pkg::entry_t entry,
    input  wire logic                  routine_ready,
    input  wire logic                  cpu_halted,
    // To the entry logic
    output logic                       instr_boundary,
    output logic [11:0]                core_pc,
    output logic                       return_from_service
);
    logic [2:0] phase;
    logic [2:0] ret_dly;

    // Pc moves mid-instruction, so it is steady around each boundary
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase   <= 3'h0;
            core_pc <= 12'h100;
            ret_dly <= 3'h0;
        end else begin
            if (!cpu_halted)
                phase <= phase + 3'h1;
            if (entry.valid)
                core_pc <= entry.vector;
            else if (!cpu_halted && phase == 3'h4)
                core_pc <= core_pc + 12'h001;
            ret_dly <= {ret_dly[1:0], routine_ready};
        end
    end

    assign instr_boundary = !cpu_halted && (phase == 3'h0);
    // Routine body stands in for saving and polling
    assign return_from_service = ret_dly[2];
endmodule

/* File: verification/test_interrupt_entry_and_sleep_control.sv */
// Purpose: Self-checking bench for interrupt entry and sleep control
// Assumes: Core model paces instructions; pins idle high
// Notes:   Each scenario drives the block and judges the result itself
module test_interrupt_entry_and_sleep_control;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  pclk, presetn, psel, penable, pwrite;
    logic [11:0]           paddr, core_pc;
    logic [31:0]           pwdata, prdata, rd;
    logic                  pready, pslverr, er, nmi_pin, port_a_pin;
    logic                  port_b_pin, timer_underflow_flag;
    logic                  converter_done_flag, instr_boundary, wait_exec;
    logic                  stop_exec, return_from_service;
    logic                  option_clear_early, watchdog_active;
    logic                  stop_with_watchdog_option, routine_ready;
    logic                  cpu_halted, osc_enable, watchdog_freeze, cpu_tick;
    irq_sleep_pkg::entry_t entry;
    int                    miscompares, num_checks, entries, cyc, w;

    irq_sleep_ctrl i_dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .nmi_pin, .port_a_pin, .port_b_pin,
        .timer_underflow_flag, .converter_done_flag, .instr_boundary,
        .core_pc, .wait_exec, .stop_exec, .return_from_service,
        .option_clear_early, .watchdog_active, .stop_with_watchdog_option,
        .entry, .routine_ready, .cpu_halted, .osc_enable, .watchdog_freeze,
        .cpu_tick);
    core_model i_core (.pclk, .presetn, .entry, .routine_ready,
        .cpu_halted, .instr_boundary, .core_pc, .return_from_service);

    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (entry.valid === 1'b1)
            entries <= entries + 1;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        #1;
    endtask

    // Whole byte, reserved bits zero
    task automatic opt(input logic [7:0] v);
        apb(1'b1, irq_sleep_pkg::OPTION_ADDR,
            {24'h0, v & irq_sleep_pkg::OPTION_MASK});
    endtask

    // Main oscillator stays the active one, no aux switch
    task automatic sleep(input logic stop);
        @(posedge pclk);
        wait_exec <= !stop;
        stop_exec <= stop;
        @(posedge pclk);
        wait_exec <= 1'b0;
        stop_exec <= 1'b0;
        tick(3);
        check(cpu_halted, 1'b1);
    endtask

    // Waits for one entry, then follows its routine to the return
    task automatic take(input logic [11:0] vec,
                        input irq_sleep_pkg::flag_set_t fl);
        int t0;
        int n0;
        w = 0;
        while (entry.valid !== 1'b1 && w < 4000) begin
            tick(1);
            w++;
        end
        t0 = cyc;
        n0 = entries;
        check(entry.valid, 1'b1);
        check(entry.vector, vec);
        check(entry.stacked_pc, core_pc);
        check(entry.flags, fl);
        nmi_pin    <= 1'b1;
        port_a_pin <= 1'b1;
        if (vec == irq_sleep_pkg::VEC_TIMER)
            timer_underflow_flag <= 1'b0;
        if (vec == irq_sleep_pkg::VEC_CONVERTER)
            converter_done_flag <= 1'b0;
        apb(1'b0, irq_sleep_pkg::STATUS_ADDR, 32'h0);
        // Any entry puts the block in interrupt mode
        check(rd[4:3], (fl == irq_sleep_pkg::FLAGS_NMI) ? fl
              : irq_sleep_pkg::FLAGS_SERVICE);
        while (routine_ready !== 1'b1 && cyc - t0 < 200)
            tick(1);
        check(cyc - t0 > (irq_sleep_pkg::RESP_MIN_CPU - 1) *
              irq_sleep_pkg::OSC_PER_CPU && cyc - t0 <=
              irq_sleep_pkg::RESP_MIN_CPU * irq_sleep_pkg::OSC_PER_CPU + 2,
              1'b1);
        tick(4);
        check(entries, n0 + 1);
    endtask

    task automatic t_latch();
        @(posedge pclk);
        port_a_pin <= 1'b0;
        tick(4);
        port_a_pin <= 1'b1;
        tick(40);
        check(entries, 0);
        opt(8'h10);
        take(irq_sleep_pkg::VEC_PORT_A, irq_sleep_pkg::FLAGS_SERVICE);
    endtask

    task automatic t_regs();
        check(osc_enable, 1'b1);
        apb(1'b0, irq_sleep_pkg::STATUS_ADDR, 32'h0);
        check(rd[7:5], irq_sleep_pkg::ST_RUN);
        opt(8'h70);
        apb(1'b0, irq_sleep_pkg::OPTION_ADDR, 32'h0);
        check(rd, 32'h0);
        apb(1'b1, 12'h0d0, 32'h0);
        check(er, 1'b1);
        opt(8'h00);
    endtask

    task automatic t_prio();
        @(posedge pclk);
        timer_underflow_flag <= 1'b1;
        converter_done_flag  <= 1'b1;
        port_a_pin           <= 1'b0;
        port_b_pin           <= 1'b0;
        tick(4);
        port_b_pin <= 1'b1;
        port_a_pin <= 1'b1;
        nmi_pin    <= 1'b0;
        take(irq_sleep_pkg::VEC_NMI, irq_sleep_pkg::FLAGS_NMI);
        opt(8'h10);
        take(irq_sleep_pkg::VEC_PORT_A, irq_sleep_pkg::FLAGS_SERVICE);
        take(irq_sleep_pkg::VEC_PORT_B, irq_sleep_pkg::FLAGS_SERVICE);
        take(irq_sleep_pkg::VEC_TIMER, irq_sleep_pkg::FLAGS_SERVICE);
        take(irq_sleep_pkg::VEC_CONVERTER,
             irq_sleep_pkg::FLAGS_SERVICE);
        tick(20);
        apb(1'b0, irq_sleep_pkg::STATUS_ADDR, 32'h0);
        check(rd[4:3], irq_sleep_pkg::FLAGS_NORMAL);
    endtask

    task automatic t_edges();
        opt(8'h30);
        port_b_pin <= 1'b0;
        tick(30);
        check(entries, 6);
        port_b_pin <= 1'b1;
        take(irq_sleep_pkg::VEC_PORT_B, irq_sleep_pkg::FLAGS_SERVICE);
        opt(8'h50);
        port_a_pin <= 1'b0;
        take(irq_sleep_pkg::VEC_PORT_A, irq_sleep_pkg::FLAGS_SERVICE);
        opt(8'h10);
        option_clear_early <= 1'b1;
        port_a_pin         <= 1'b0;
        take(irq_sleep_pkg::VEC_PORT_A, irq_sleep_pkg::FLAGS_NORMAL);
        option_clear_early <= 1'b0;
    endtask

    task automatic t_sleep();
        // Sleep refused while a request is pending
        @(posedge pclk);
        timer_underflow_flag <= 1'b1;
        wait_exec            <= 1'b1;
        @(posedge pclk);
        wait_exec <= 1'b0;
        tick(0);
        check(cpu_halted, 1'b0);
        take(irq_sleep_pkg::VEC_TIMER,
             irq_sleep_pkg::FLAGS_SERVICE);
        sleep(1'b0);
        tick(50);
        check(osc_enable & cpu_halted, 1'b1);
        timer_underflow_flag <= 1'b1;
        take(irq_sleep_pkg::VEC_TIMER, irq_sleep_pkg::FLAGS_SERVICE);
        sleep(1'b0);
        converter_done_flag <= 1'b1;
        take(irq_sleep_pkg::VEC_CONVERTER,
             irq_sleep_pkg::FLAGS_SERVICE);
        sleep(1'b1);
        check(osc_enable, 1'b0);
        converter_done_flag <= 1'b1;
        tick(100);
        check(cpu_halted, 1'b1);
        converter_done_flag <= 1'b0;
        port_b_pin          <= 1'b0;
        take(irq_sleep_pkg::VEC_PORT_B, irq_sleep_pkg::FLAGS_SERVICE);
        check(w >= 2048 && w <= 2100, 1'b1);
        port_b_pin <= 1'b1;
    endtask

    task automatic t_wdog();
        watchdog_active <= 1'b1;
        sleep(1'b1);
        check({osc_enable, watchdog_freeze}, 2'b10);
        timer_underflow_flag <= 1'b1;
        take(irq_sleep_pkg::VEC_TIMER, irq_sleep_pkg::FLAGS_SERVICE);
        stop_with_watchdog_option <= 1'b1;
        sleep(1'b1);
        check({osc_enable, watchdog_freeze}, 2'b01);
        port_a_pin <= 1'b0;
        take(irq_sleep_pkg::VEC_PORT_A, irq_sleep_pkg::FLAGS_SERVICE);
        check(w >= 2048, 1'b1);
        watchdog_active <= 1'b0;
        opt(8'h00);
        sleep(1'b0);
        nmi_pin <= 1'b0;
        tick(100);
        check(cpu_halted, 1'b1);
        opt(8'h10);
        take(irq_sleep_pkg::VEC_NMI, irq_sleep_pkg::FLAGS_NMI);
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata, timer_underflow_flag,
         converter_done_flag, wait_exec, stop_exec, option_clear_early,
         watchdog_active, stop_with_watchdog_option, presetn} = '0;
        {nmi_pin, port_a_pin, port_b_pin} = 3'b111;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        tick(1);
        t_latch();
        t_regs();
        t_prio();
        t_edges();
        t_sleep();
        t_wdog();
        report_and_stop();
    end

    initial begin
        repeat (60000) @(posedge pclk);
        miscompares++;
        report_and_stop();
    end
endmodule
